// ==== rtl/charge_limit_pkg.sv ====
/*
 Constants for the charge voltage and input current limit registers:
 command codes, field positions, legal code ranges, reset values, timing.
 Assumes a 50 MHz block clock.
*/
package charge_limit_pkg;

	// ==========================================================
	// Command codes and field layout
	localparam logic [7:0] SET_CHARGE_VOLTAGE_CMD = 8'h15;
	localparam logic [7:0] SET_INPUT_LIMIT_CMD = 8'h3F;
	localparam int VOLT_FIELD_LSB = 4;
	localparam int VOLT_FIELD_W = 11;
	localparam int INPUT_FIELD_LSB = 7;
	localparam int INPUT_FIELD_W = 6;
	localparam int WORD_W = 16;

	// ==========================================================
	// Legal codes: volts 1024..19200 mV in 16 mV steps, current 128..8064 mA in 128 mA steps
	localparam logic [10:0] VOLT_CODE_MIN = 11'h040;
	localparam logic [10:0] VOLT_CODE_MAX = 11'h4B0;
	localparam logic [5:0] INPUT_CODE_MIN = 6'h01;
	localparam logic [5:0] INPUT_CODE_MAX = 6'h3F;
	localparam logic [10:0] VOLT_CODE_RESET = 11'h000;
	localparam logic [5:0] INPUT_CODE_RESET = 6'h20;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int OVERLOAD_DELAY_NS = 260000;
	localparam int OVERLOAD_CYCLES = OVERLOAD_DELAY_NS / CLK_PERIOD_NS;
	localparam int SOFT_START_NS = 1280;
	localparam int SOFT_START_CYCLES = (SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OVL_CNT_W = 16;

	typedef enum logic [1:0] {
		OVL_RUN,
		OVL_REDUCE,
		OVL_SHUTDOWN,
		OVL_SOFT_START
	} ovl_state_t;

endpackage

// ==== rtl/charge_voltage_input_current_regs.sv ====
/*
 Charge voltage and input current limit registers of a battery charge
 controller, with the fast input-overload shutdown and soft restart.
 Assumes an SMBus engine on the same clock that hands over decoded word
 writes and reads as one-cycle strobes; comparator inputs are asynchronous.
*/
`timescale 1ns/1ps
module charge_voltage_input_current_regs #(
	parameter int unsigned OVERLOAD_CYCLES = charge_limit_pkg::OVERLOAD_CYCLES
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic cmdWrite,
	input wire logic cmdRead,
	input wire logic [7:0] cmdCode,
	input wire logic [charge_limit_pkg::WORD_W-1:0] cmdWrData,
	output logic [charge_limit_pkg::WORD_W-1:0] rdData,
	output logic rdValid,
	output logic cmdError,
	input wire logic overInputLimit,
	input wire logic overFastThreshold,
	input wire logic adapterCanCharge,
	output logic [charge_limit_pkg::VOLT_FIELD_W-1:0] voltageCode,
	output logic [charge_limit_pkg::INPUT_FIELD_W-1:0] inputLimitCode,
	output logic chargeEnable,
	output logic chargeReduce,
	output logic overloadShutdown
);
	import charge_limit_pkg::*;

	// ==========================================================
	// Input synchronisers
	// Comparator levels are asynchronous: two flops before any logic reads them
	logic [2:0] syncA_q;
	logic [2:0] syncB_q;
	logic limitSync;
	logic fastSync;
	logic canSync;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			syncA_q <= 3'h0;
			syncB_q <= 3'h0;
		end else begin
			syncA_q <= {adapterCanCharge, overFastThreshold, overInputLimit};
			syncB_q <= syncA_q;
		end
	end

	assign limitSync = syncB_q[0];
	assign fastSync = syncB_q[1];
	assign canSync = syncB_q[2];

	// ==========================================================
	// Field helpers
	function automatic logic [VOLT_FIELD_W-1:0] voltField(input logic [WORD_W-1:0] w);
		voltField = w[VOLT_FIELD_LSB +: VOLT_FIELD_W];
	endfunction

	function automatic logic [INPUT_FIELD_W-1:0] inputField(input logic [WORD_W-1:0] w);
		inputField = w[INPUT_FIELD_LSB +: INPUT_FIELD_W];
	endfunction

	function automatic logic voltInRange(input logic [VOLT_FIELD_W-1:0] code);
		voltInRange = (code >= VOLT_CODE_MIN) && (code <= VOLT_CODE_MAX);
	endfunction

	function automatic logic inputInRange(input logic [INPUT_FIELD_W-1:0] code);
		inputInRange = (code >= INPUT_CODE_MIN) && (code <= INPUT_CODE_MAX);
	endfunction

	// ==========================================================
	// Register file
	logic [VOLT_FIELD_W-1:0] voltageCode_d;
	logic [INPUT_FIELD_W-1:0] inputLimitCode_d;
	logic [WORD_W-1:0] rdData_d;
	logic rdValid_d;
	logic cmdError_d;
	logic voltWrite;
	logic inputWrite;

	assign voltWrite = cmdWrite && (cmdCode == SET_CHARGE_VOLTAGE_CMD);
	assign inputWrite = cmdWrite && (cmdCode == SET_INPUT_LIMIT_CMD);

	always_comb begin
		voltageCode_d = voltageCode;
		inputLimitCode_d = inputLimitCode;
		rdData_d = rdData;
		rdValid_d = 1'b0;
		cmdError_d = 1'b0;
		if (voltWrite) begin
			if (voltInRange(voltField(cmdWrData))) begin
				voltageCode_d = voltField(cmdWrData);
			end else begin
				voltageCode_d = '0;
			end
		end
		if (inputWrite) begin
			if (inputInRange(inputField(cmdWrData))) begin
				inputLimitCode_d = inputField(cmdWrData);
			end else begin
				inputLimitCode_d = '0;
			end
		end
		if (cmdWrite && !voltWrite && !inputWrite) begin
			cmdError_d = 1'b1;
		end
		// A read in the same cycle as a write returns the old value
		if (cmdRead) begin
			rdValid_d = 1'b1;
			rdData_d = '0;
			if (cmdCode == SET_CHARGE_VOLTAGE_CMD) begin
				rdData_d[VOLT_FIELD_LSB +: VOLT_FIELD_W] = voltageCode;
			end else if (cmdCode == SET_INPUT_LIMIT_CMD) begin
				rdData_d[INPUT_FIELD_LSB +: INPUT_FIELD_W] = inputLimitCode;
			end else begin
				cmdError_d = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			voltageCode <= VOLT_CODE_RESET;
			inputLimitCode <= INPUT_CODE_RESET;
			rdData <= '0;
			rdValid <= 1'b0;
			cmdError <= 1'b0;
		end else begin
			voltageCode <= voltageCode_d;
			inputLimitCode <= inputLimitCode_d;
			rdData <= rdData_d;
			rdValid <= rdValid_d;
			cmdError <= cmdError_d;
		end
	end

	// ==========================================================
	// Fast overload shutdown and soft restart
	ovl_state_t state_q;
	ovl_state_t state_d;
	logic [OVL_CNT_W-1:0] ovlCnt_q;
	logic [OVL_CNT_W-1:0] ovlCnt_d;
	logic chargeEnable_d;
	logic chargeReduce_d;
	logic overloadShutdown_d;
	logic settingsValid;

	// Next values, so charging stops on the same edge that clears a register
	assign settingsValid = (voltageCode_d != '0) && (inputLimitCode_d != '0);

	always_comb begin
		state_d = state_q;
		ovlCnt_d = ovlCnt_q;
		unique case (state_q)
			OVL_RUN: begin
				ovlCnt_d = '0;
				if (fastSync) begin
					state_d = OVL_REDUCE;
				end
			end
			OVL_REDUCE: begin
				ovlCnt_d = ovlCnt_q + 1'b1;
				if (!fastSync) begin
					state_d = OVL_RUN;
				end else if (ovlCnt_q == OVL_CNT_W'(OVERLOAD_CYCLES - 1)) begin
					state_d = OVL_SHUTDOWN;
				end
			end
			OVL_SHUTDOWN: begin
				ovlCnt_d = '0;
				if (!fastSync && canSync) begin
					state_d = OVL_SOFT_START;
				end
			end
			OVL_SOFT_START: begin
				// A new overload during the ramp starts a full count again
				ovlCnt_d = ovlCnt_q + 1'b1;
				if (fastSync) begin
					state_d = OVL_REDUCE;
					ovlCnt_d = '0;
				end else if (ovlCnt_q == OVL_CNT_W'(SOFT_START_CYCLES - 1)) begin
					state_d = OVL_RUN;
				end
			end
		endcase
		chargeEnable_d = settingsValid && (state_d != OVL_SHUTDOWN);
		chargeReduce_d = limitSync || (state_d != OVL_RUN);
		overloadShutdown_d = (state_d == OVL_SHUTDOWN);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= OVL_RUN;
			ovlCnt_q <= '0;
			chargeEnable <= 1'b0;
			chargeReduce <= 1'b0;
			overloadShutdown <= 1'b0;
		end else begin
			state_q <= state_d;
			ovlCnt_q <= ovlCnt_d;
			chargeEnable <= chargeEnable_d;
			chargeReduce <= chargeReduce_d;
			overloadShutdown <= overloadShutdown_d;
		end
	end

	// ==========================================================
	// Assertions
	localparam int SOFT_SPAN = SOFT_START_CYCLES + 1;
	logic firstCycle_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			firstCycle_q <= 1'b1;
		end else begin
			firstCycle_q <= 1'b0;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	sequence restartCond;
		state_q == OVL_SHUTDOWN && !fastSync && canSync;
	endsequence

	sequence softRamp;
		(state_q == OVL_SOFT_START && chargeReduce && !overloadShutdown);
	endsequence

	sequence overloadEntry;
		state_q == OVL_RUN && fastSync;
	endsequence

	a_volt_write_store: assert property (voltWrite && voltField(cmdWrData) >= 11'h040
		&& voltField(cmdWrData) <= 11'h4B0 |=> voltageCode == $past(cmdWrData[14:4]))
		else $error("voltage setting not stored");
	a_volt_range_clear: assert property (voltWrite && (voltField(cmdWrData) < 11'h040
		|| voltField(cmdWrData) > 11'h4B0) |=> voltageCode == 11'h000 && !chargeEnable)
		else $error("bad voltage not cleared");
	a_volt_hold_idle: assert property (!voltWrite |=> $stable(voltageCode))
		else $error("voltage changed without write");
	a_reset_values: assert property (firstCycle_q |-> voltageCode == 11'h000 && inputLimitCode == 6'h20)
		else $error("wrong reset settings");
	a_input_write_store: assert property (inputWrite && cmdWrData[12:7] != 6'h00
		|=> inputLimitCode == $past(cmdWrData[12:7])) else $error("input limit not stored");
	a_input_range_clear: assert property (inputWrite && cmdWrData[12:7] == 6'h00
		|=> inputLimitCode == 6'h00 && !chargeEnable) else $error("bad input limit not cleared");
	a_input_hold_idle: assert property (!inputWrite |=> $stable(inputLimitCode))
		else $error("input limit changed without write");
	a_enable_settings: assert property (chargeEnable |-> voltageCode != 11'h000 && inputLimitCode != 6'h00)
		else $error("charging with a cleared setting");

	// ==========================================================
	// Register reads and unknown codes
	a_read_unused_zero: assert property (cmdRead |=> rdValid && rdData[15] == 1'b0 && rdData[3:0] == 4'h0)
		else $error("unused bits read nonzero");
	a_read_volt_data: assert property (cmdRead && cmdCode == SET_CHARGE_VOLTAGE_CMD
		|=> rdData[14:4] == $past(voltageCode)) else $error("voltage read back wrong");
	a_read_input_data: assert property (cmdRead && cmdCode == SET_INPUT_LIMIT_CMD
		|=> rdData[12:7] == $past(inputLimitCode) && rdData[15:13] == 3'h0 && rdData[6:0] == 7'h00)
		else $error("input limit read back wrong");
	a_read_unknown: assert property (cmdRead && cmdCode != SET_CHARGE_VOLTAGE_CMD
		&& cmdCode != SET_INPUT_LIMIT_CMD |=> cmdError && rdData == 16'h0000)
		else $error("unknown read not refused");
	a_write_unknown: assert property (cmdWrite && cmdCode != SET_CHARGE_VOLTAGE_CMD
		&& cmdCode != SET_INPUT_LIMIT_CMD |=> cmdError && $stable(voltageCode) && $stable(inputLimitCode))
		else $error("unknown write not refused");
	a_strobe_idle: assert property (!cmdWrite && !cmdRead |=> !rdValid && !cmdError)
		else $error("answer without a request");

	// ==========================================================
	// Input limit and overload sequencing
	a_limit_reduce: assert property (limitSync |=> chargeReduce) else $error("no reduction over input limit");
	a_overload_enter: assert property (overloadEntry
		|=> state_q == OVL_REDUCE && ovlCnt_q == '0 && chargeReduce) else $error("fast overload not taken");
	a_fast_release: assert property (state_q == OVL_REDUCE && !fastSync |=> state_q == OVL_RUN)
		else $error("overload count not abandoned");
	a_ovl_shutdown: assert property (state_q == OVL_REDUCE && fastSync
		&& ovlCnt_q == OVL_CNT_W'(OVERLOAD_CYCLES - 1) |=> overloadShutdown && !chargeEnable)
		else $error("overload did not shut down");
	a_shutdown_hold: assert property (state_q == OVL_SHUTDOWN && (fastSync || !canSync)
		|=> overloadShutdown && !chargeEnable) else $error("shutdown left too early");
	a_soft_restart: assert property (restartCond |=> softRamp ##[1:SOFT_SPAN] (state_q != OVL_SOFT_START))
		else $error("soft restart did not run");
	a_soft_end: assert property (state_q == OVL_SOFT_START && !fastSync && !limitSync
		&& ovlCnt_q == OVL_CNT_W'(SOFT_START_CYCLES - 1) |=> !chargeReduce && state_q == OVL_RUN)
		else $error("soft restart did not release");

endmodule

// ==== verif/smbus_host_model.sv ====
/*
 Host-side model of the power-management controller: word writes and reads as one-cycle strobes.
 Assumes the register block samples its command port on the rising edge of ref_clk.
*/
`timescale 1ns/1ps
module smbus_host_model (
	input wire logic ref_clk,
	output logic cmdWrite,
	output logic cmdRead,
	output logic [7:0] cmdCode,
	output logic [15:0] cmdWrData
);
	initial begin
		cmdWrite = 1'b0;
		cmdRead = 1'b0;
		cmdCode = 8'h00;
		cmdWrData = 16'h0000;
	end
	// ==========================================================
	// One 16-bit word per strobe; idle lines are scrambled afterwards
	task automatic xfer(input logic wr, input logic rd, input logic [7:0] code, input logic [15:0] data);
		@(posedge ref_clk) #1;
		cmdWrite = wr;
		cmdRead = rd;
		cmdCode = code;
		cmdWrData = data;
		@(posedge ref_clk) #1;
		cmdWrite = 1'b0;
		cmdRead = 1'b0;
		cmdCode = ~code;
		cmdWrData = ~data;
	endtask
endmodule

// ==== verif/tb.sv ====
/*
 Self-checking bench for the charge voltage and input current registers.
 Assumes the host model drives the command port; comparator levels come from here.
*/
`timescale 1ns/1ps
module tb;
	import charge_limit_pkg::*;
	localparam int OVL = 20;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic overInputLimit = 1'b0;
	logic overFastThreshold = 1'b0;
	logic adapterCanCharge = 1'b0;
	logic cmdWrite, cmdRead, rdValid, cmdError, chargeEnable, chargeReduce, overloadShutdown;
	logic [7:0] cmdCode;
	logic [15:0] cmdWrData, rdData;
	logic [10:0] voltageCode;
	logic [5:0] inputLimitCode;
	int failures = 0;
	int nCompared = 0;
	int volt = 0;
	int inl = 32;
	int vc[6] = '{'h03F, 'h040, 'h4B0, 'h4B1, 'h7FF, 0};

	always #10 ref_clk = ~ref_clk;

	smbus_host_model host (.ref_clk(ref_clk), .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode),
		.cmdWrData(cmdWrData));
	charge_voltage_input_current_regs #(.OVERLOAD_CYCLES(OVL)) uut (.ref_clk(ref_clk), .nrst(nrst),
		.cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode), .cmdWrData(cmdWrData), .rdData(rdData),
		.rdValid(rdValid), .cmdError(cmdError), .overInputLimit(overInputLimit),
		.overFastThreshold(overFastThreshold), .adapterCanCharge(adapterCanCharge), .voltageCode(voltageCode),
		.inputLimitCode(inputLimitCode), .chargeEnable(chargeEnable), .chargeReduce(chargeReduce),
		.overloadShutdown(overloadShutdown));

	// ==========================================================
	// Comparison, waiting and verdict
	task automatic end_sim();
		$display("compared=%0d failures=%0d", nCompared, failures);
		if (failures == 0 && nCompared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic waitv(ref logic s, input logic v, output int n);
		for (n = 1; n <= 200; n++) begin
			@(posedge ref_clk) #1;
			if (s === v) return;
		end
		failures++;
		end_sim();
	endtask

	// ==========================================================
	// Register accesses against the integer model
	task automatic cmp();
		check(16'(voltageCode), 16'(volt));
		check(16'(inputLimitCode), 16'(inl));
		check(16'(chargeEnable), 16'(volt != 0 && inl != 0));
	endtask

	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		int c;
		host.xfer(1'b1, 1'b0, code, data);
		c = (data >> 4) & 'h7FF;
		if (code == SET_CHARGE_VOLTAGE_CMD) volt = (c < 64 || c > 1200) ? 0 : c;
		if (code == SET_INPUT_LIMIT_CMD) inl = (data >> 7) & 'h3F;
		check(16'(cmdError), 16'(code != SET_CHARGE_VOLTAGE_CMD && code != SET_INPUT_LIMIT_CMD));
		cmp();
	endtask

	task automatic rd(input logic [7:0] code);
		host.xfer(1'b0, 1'b1, code, 16'($urandom));
		check(16'(rdValid), 16'h0001);
		check(16'(cmdError), 16'(code != SET_CHARGE_VOLTAGE_CMD && code != SET_INPUT_LIMIT_CMD));
		check(rdData, code == SET_CHARGE_VOLTAGE_CMD ? 16'(volt << 4) :
			code == SET_INPUT_LIMIT_CMD ? 16'(inl << 7) : 16'h0000);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		int c;
		int n;
		void'($urandom(36259));
		repeat (12) @(posedge ref_clk);
		#1 nrst = 1'b1;
		cmp();
		for (int i = 0; i < 24; i++) begin
			c = (i < 6) ? vc[i] : $urandom_range(0, 1300);
			wr(SET_CHARGE_VOLTAGE_CMD, 16'($urandom) & 16'h800F | 16'(c << 4));
			rd(SET_CHARGE_VOLTAGE_CMD);
			c = (i == 0) ? 0 : (i == 1) ? 63 : $urandom_range(4, 63);
			wr(SET_INPUT_LIMIT_CMD, 16'($urandom) & 16'hE07F | 16'(c << 7));
			rd(SET_INPUT_LIMIT_CMD);
		end
		wr(8'h14, 16'h1234);
		rd(8'hA5);
		wr(SET_CHARGE_VOLTAGE_CMD, 16'h3140);
		@(posedge ref_clk) #1 overInputLimit = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 check(16'(chargeReduce), 16'h0000);
		@(posedge ref_clk) #1 check(16'(chargeReduce), 16'h0001);
		overInputLimit = 1'b0;
		overFastThreshold = 1'b1;
		repeat (10) @(posedge ref_clk);
		#1 overFastThreshold = 1'b0;
		repeat (30) @(posedge ref_clk) #1 check(16'(overloadShutdown), 16'h0000);
		overFastThreshold = 1'b1;
		waitv(overloadShutdown, 1'b1, n);
		check(16'(n), 16'(OVL + 3));
		check(16'(chargeEnable), 16'h0000);
		overFastThreshold = 1'b0;
		repeat (10) @(posedge ref_clk) #1 check(16'(overloadShutdown), 16'h0001);
		adapterCanCharge = 1'b1;
		waitv(chargeEnable, 1'b1, n);
		check(16'(n), 16'h0003);
		waitv(chargeReduce, 1'b0, n);
		check(16'(n), 16'h0040);
		nrst = 1'b0;
		volt = 0;
		inl = 32;
		#5 cmp();
		check(16'(overloadShutdown), 16'h0000);
		check(16'(chargeReduce), 16'h0000);
		check(16'(rdValid), 16'h0000);
		@(posedge ref_clk) #1 nrst = 1'b1;
		cmp();
		rd(SET_INPUT_LIMIT_CMD);
		wr(SET_INPUT_LIMIT_CMD, 16'h0200);
		wr(SET_CHARGE_VOLTAGE_CMD, 16'(VOLT_CODE_MAX) << 4);
		rd(SET_CHARGE_VOLTAGE_CMD);
		check(16'(chargeReduce), 16'h0000);
		end_sim();
	end
endmodule
